//--- design/ccm_packet_packet_task_a_config.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module ccm_packet_packet_task_a_config
	import ccm_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic keystream_generate_task,
	input wire logic packet_task_a,
	input wire logic rate_override_task,
	output logic op_start,
	output logic op_decrypt,
	output logic [1:0] op_rate,
	output logic op_ext_len,
	output logic [3:0] op_length_bits,
	output logic [7:0] op_keystream_len,
	output logic [31:0] op_key_nonce_ptr,
	output logic [31:0] op_in_ptr,
	output logic [31:0] op_out_ptr,
	output logic [31:0] op_scratch_ptr
);

	// ******************************
	// state
	// ******************************
	typedef struct packed {
		logic mode_decrypt;
		radio_rate_type mode_rate;
		logic mode_ext;
		logic [31:0] key_ptr;
		logic [31:0] in_ptr;
		logic [31:0] out_ptr;
		logic [31:0] scratch_ptr;
		logic [7:0] max_len;
		radio_rate_type ovr_rate;
		logic act_decrypt;
		radio_rate_type act_rate;
		logic act_ext;
		logic [7:0] act_kslen;
		logic start;
		logic [31:0] rdata;
	} cfg_type;

	cfg_type s_r;
	cfg_type s_nxt;

	logic rd_take;
	logic wr_pend;
	logic [ADDR_BITS-1:0] wr_addr;
	logic op_trigger;
	logic [7:0] max_len_in;
	logic [31:0] rd_word;

	// ******************************
	// bus front end
	// ******************************
	ahb_front u_front (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.rd_take(rd_take),
		.wr_pend(wr_pend),
		.wr_addr(wr_addr)
	);

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = s_r.rdata;

	// either operation task starts a new operation
	assign op_trigger = keystream_generate_task || packet_task_a;

	// max length write kept inside its legal range
	always_comb begin
		max_len_in = hwdata[POS_MAX_LEN +: 8];
		if (hwdata[POS_MAX_LEN +: 8] < MAX_LEN_LO) begin
			max_len_in = MAX_LEN_LO;
		end else if (hwdata[POS_MAX_LEN +: 8] > MAX_LEN_HI) begin
			max_len_in = MAX_LEN_HI;
		end
	end

	// ******************************
	// pointer snapshots per operation
	// ******************************
	snap_word #(.WIDTH(32)) u_key_snap (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(op_trigger),
		.din(s_r.key_ptr),
		.dout(op_key_nonce_ptr)
	);

	snap_word #(.WIDTH(32)) u_in_snap (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(op_trigger),
		.din(s_r.in_ptr),
		.dout(op_in_ptr)
	);

	snap_word #(.WIDTH(32)) u_out_snap (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(op_trigger),
		.din(s_r.out_ptr),
		.dout(op_out_ptr)
	);

	snap_word #(.WIDTH(32)) u_scratch_snap (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(op_trigger),
		.din(s_r.scratch_ptr),
		.dout(op_scratch_ptr)
	);

	// ******************************
	// operation outputs
	// ******************************
	assign op_start = s_r.start;
	assign op_decrypt = s_r.act_decrypt;
	assign op_rate = s_r.act_rate;
	assign op_ext_len = s_r.act_ext;
	assign op_keystream_len = s_r.act_kslen;

	// length field width follows the active length mode
	always_comb begin
		if (s_r.act_ext) begin
			op_length_bits = LEN_BITS_EXT;
		end else begin
			op_length_bits = LEN_BITS_DEFAULT;
		end
	end

	// ******************************
	// next state
	// ******************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;

		// data phase write into the addressed register
		if (wr_pend) begin
			case (wr_addr)
				OFS_MODE: begin
					s_nxt.mode_decrypt = hwdata[POS_DIR];
					s_nxt.mode_rate = radio_rate_type'(hwdata[POS_RATE +: 2]);
					s_nxt.mode_ext = hwdata[POS_LEN];
				end
				OFS_KEY_PTR: begin
					s_nxt.key_ptr = hwdata;
				end
				OFS_IN_PTR: begin
					s_nxt.in_ptr = hwdata;
				end
				OFS_OUT_PTR: begin
					s_nxt.out_ptr = hwdata;
				end
				OFS_SCRATCH_PTR: begin
					s_nxt.scratch_ptr = hwdata;
				end
				OFS_MAX_LEN: begin
					s_nxt.max_len = max_len_in;
				end
				OFS_RATE_OVR: begin
					s_nxt.ovr_rate = radio_rate_type'(hwdata[POS_OVR +: 2]);
				end
				default: begin
				end
			endcase
		end

		// a task takes the mode as it stood before this edge
		if (op_trigger) begin
			s_nxt.act_decrypt = s_r.mode_decrypt;
			s_nxt.act_rate = s_r.mode_rate;
			s_nxt.act_ext = s_r.mode_ext;
			if (s_r.mode_ext) begin
				s_nxt.act_kslen = s_r.max_len;
			end else begin
				s_nxt.act_kslen = KS_LEN_DEFAULT;
			end
			s_nxt.start = 1'b1;
		end

		// override replaces the rate only when its task fires
		if (rate_override_task) begin
			s_nxt.act_rate = s_r.ovr_rate;
		end

		// read data from the updated state, so a write just before is seen
		rd_word = '0;
		case (haddr[ADDR_BITS-1:0])
			OFS_MODE: begin
				rd_word[POS_DIR] = s_nxt.mode_decrypt;
				rd_word[POS_RATE +: 2] = s_nxt.mode_rate;
				rd_word[POS_LEN] = s_nxt.mode_ext;
			end
			OFS_KEY_PTR: begin
				rd_word = s_nxt.key_ptr;
			end
			OFS_IN_PTR: begin
				rd_word = s_nxt.in_ptr;
			end
			OFS_OUT_PTR: begin
				rd_word = s_nxt.out_ptr;
			end
			OFS_SCRATCH_PTR: begin
				rd_word = s_nxt.scratch_ptr;
			end
			OFS_MAX_LEN: begin
				rd_word[POS_MAX_LEN +: 8] = s_nxt.max_len;
			end
			OFS_RATE_OVR: begin
				rd_word[POS_OVR +: 2] = s_nxt.ovr_rate;
			end
			OFS_ACTIVE: begin
				rd_word[POS_DIR] = s_nxt.act_decrypt;
				rd_word[POS_ACT_KSLEN +: 8] = s_nxt.act_kslen;
				rd_word[POS_RATE +: 2] = s_nxt.act_rate;
				rd_word[POS_LEN] = s_nxt.act_ext;
			end
			default: begin
				rd_word = '0;
			end
		endcase
		// read word held for the data phase until the next read
		if (rd_take) begin
			s_nxt.rdata = rd_word;
		end
	end

	// ******************************
	// registers
	// ******************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r.mode_decrypt <= RST_DIR;
			s_r.mode_rate <= RATE_1M;
			s_r.mode_ext <= RST_LEN;
			s_r.key_ptr <= RST_PTR;
			s_r.in_ptr <= RST_PTR;
			s_r.out_ptr <= RST_PTR;
			s_r.scratch_ptr <= RST_PTR;
			s_r.max_len <= RST_MAX_LEN;
			s_r.ovr_rate <= RATE_1M;
			s_r.act_decrypt <= RST_DIR;
			s_r.act_rate <= RATE_1M;
			s_r.act_ext <= RST_LEN;
			s_r.act_kslen <= KS_LEN_DEFAULT;
			s_r.start <= 1'b0;
			s_r.rdata <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // ccm_packet_packet_task_a_config

//--- design/ccm_cfg_pkg.sv
// How it works
// - each keystream or packet_task_a task takes a fresh copy of the mode register for that operation.
// - mode bit 0 picks encrypt at 0 and decrypt at 1, and reset leaves it at decrypt.
// - the two-bit rate field picks 1 Mbps, 2 Mbps, 125 Kbps or 500 Kbps for codes 0 to 3.
// - length mode 0 gives a 5-bit length field and a keystream for at most 27 payload bytes.
// - length mode 1 gives an 8-bit length field and a keystream as long as the max length register.
// - the key and nonce are fetched from the address held in the 32-bit key/nonce pointer.
// - the max length register holds 0x1b to 0xfb in its low byte and resets to 0xfb.
// - the rate override register holds a rate that replaces the configured rate when applied.
// - the override rate is applied only by the rate override task, otherwise the mode rate holds.
package ccm_cfg_pkg;

	// ******************************
	// register byte offsets
	// ******************************
	localparam logic [11:0] OFS_MODE = 12'h504;
	localparam logic [11:0] OFS_KEY_PTR = 12'h508;
	localparam logic [11:0] OFS_IN_PTR = 12'h50c;
	localparam logic [11:0] OFS_OUT_PTR = 12'h510;
	localparam logic [11:0] OFS_SCRATCH_PTR = 12'h514;
	localparam logic [11:0] OFS_MAX_LEN = 12'h518;
	localparam logic [11:0] OFS_RATE_OVR = 12'h51c;
	localparam logic [11:0] OFS_ACTIVE = 12'h520;
	localparam int ADDR_BITS = 12;

	// ******************************
	// field positions
	// ******************************
	localparam int POS_DIR = 0;
	localparam int POS_RATE = 16;
	localparam int POS_LEN = 24;
	localparam int POS_ACT_KSLEN = 8;
	localparam int POS_MAX_LEN = 0;
	localparam int POS_OVR = 0;

	// ******************************
	// reset values and limits
	// ******************************
	localparam logic RST_DIR = 1'h1;
	localparam logic [1:0] RST_RATE = 2'h0;
	localparam logic RST_LEN = 1'h0;
	localparam logic [31:0] RST_PTR = 32'h0000_0000;
	localparam logic [7:0] RST_MAX_LEN = 8'hfb;
	localparam logic [1:0] RST_OVR = 2'h0;
	localparam logic [7:0] MAX_LEN_LO = 8'h1b;
	localparam logic [7:0] MAX_LEN_HI = 8'hfb;
	localparam logic [7:0] KS_LEN_DEFAULT = 8'h1b;
	localparam logic [3:0] LEN_BITS_DEFAULT = 4'h5;
	localparam logic [3:0] LEN_BITS_EXT = 4'h8;

	// ******************************
	// bus codes
	// ******************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		RATE_1M = 2'h0,
		RATE_2M = 2'h1,
		RATE_125K = 2'h2,
		RATE_500K = 2'h3
	} radio_rate_type;

endpackage

//--- design/ahb_front.sv
`timescale 1ns/1ns
// ******************************
// ahb-lite address phase capture
// ******************************
module ahb_front
	import ccm_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	output logic rd_take,
	output logic wr_pend,
	output logic [ADDR_BITS-1:0] wr_addr
);

	typedef struct packed {
		logic wr;
		logic [ADDR_BITS-1:0] addr;
	} front_type;

	front_type s_r;
	front_type s_nxt;
	logic take;

	// a transfer is taken when selected, active and the bus is ready
	assign take = hsel && htrans[1] && hready;
	assign rd_take = take && !hwrite;
	assign wr_pend = s_r.wr;
	assign wr_addr = s_r.addr;

	// remember writes for their data phase
	always_comb begin
		s_nxt = s_r;
		if (hready) begin
			s_nxt.wr = take && hwrite;
			s_nxt.addr = haddr[ADDR_BITS-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // ahb_front

//--- design/snap_word.sv
`timescale 1ns/1ns
// ******************************
// word snapshot taken on a load pulse
// ******************************
module snap_word #(
	parameter int WIDTH = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] value;
	} snap_type;

	snap_type s_r;
	snap_type s_nxt;

	assign dout = s_r.value;

	// hold until the next load
	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.value = din;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // snap_word

//--- testbench/ccm_cfg_asserts.sv
`timescale 1ns/1ns
module ccm_cfg_checker
	import ccm_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic keystream_generate_task,
	input wire logic packet_task_a,
	input wire logic rate_override_task,
	input wire logic op_start,
	input wire logic op_decrypt,
	input wire logic [1:0] op_rate,
	input wire logic op_ext_len,
	input wire logic [3:0] op_length_bits,
	input wire logic [7:0] op_keystream_len,
	input wire logic [31:0] op_key_nonce_ptr
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// either operation task
	wire go = keystream_generate_task | packet_task_a;

	// ****
	// operation snapshot timing
	// ****
	property p_start; 1 |=> op_start == $past(go); endproperty
	a_start: assert property (p_start) else $error("start pulse off");
	property p_b2b; go ##1 go |-> op_start [*2]; endproperty
	a_b2b: assert property (p_b2b) else $error("back to back start lost");
	property p_hold;
		!go |=> $stable(op_decrypt) && $stable(op_ext_len) && $stable(op_key_nonce_ptr);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved without task");
	property p_rate; !go && !rate_override_task |=> $stable(op_rate); endproperty
	a_rate: assert property (p_rate) else $error("rate moved without task");
	property p_ovr; rate_override_task && !go |=> !op_start && $stable(op_keystream_len);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override started an operation");

	// ****
	// length mode outputs
	// ****
	property p_bits; op_length_bits == (op_ext_len ? LEN_BITS_EXT : LEN_BITS_DEFAULT);
	endproperty
	a_bits: assert property (p_bits) else $error("length field width wrong");
	property p_ks_def; !op_ext_len |-> op_keystream_len == KS_LEN_DEFAULT; endproperty
	a_ks_def: assert property (p_ks_def) else $error("default keystream length wrong");
	property p_ks_rng;
		op_ext_len |-> op_keystream_len >= MAX_LEN_LO && op_keystream_len <= MAX_LEN_HI;
	endproperty
	a_ks_rng: assert property (p_ks_rng) else $error("keystream length out of range");
endmodule // ccm_cfg_checker

bind ccm_packet_packet_task_a_config ccm_cfg_checker i_chk (.hclk, .hresetn, .keystream_generate_task,
	.packet_task_a, .rate_override_task, .op_start, .op_decrypt, .op_rate, .op_ext_len,
	.op_length_bits, .op_keystream_len, .op_key_nonce_ptr);

//--- testbench/ccm_packet_packet_task_a_config_tb_top.sv
`timescale 1ns/1ns
module ccm_packet_packet_task_a_config_tb_top;
	import ccm_cfg_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, kg = 0, pa = 0, ro = 0, rd_ph = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, kp, ip, opp, sp;
	logic [31:0] m[8];
	logic [1:0] htrans = 0, op_rate;
	logic hreadyout, hresp, op_start, op_decrypt, op_ext_len;
	logic [3:0] op_length_bits;
	logic [7:0] op_keystream_len;
	logic [143:0] qo[$];
	logic [31:0] qr[$];
	wire [143:0] op_seen = {op_decrypt, op_rate, op_ext_len, op_length_bits, op_keystream_len,
		kp, ip, opp, sp};
	wire [33:0] bus_seen = {hreadyout, hresp, hrdata};
	int n_fail = 0, n_compared = 0, seed = 32'h62ea;

	// clock
	always #50 hclk = ~hclk;

	ccm_packet_packet_task_a_config i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.keystream_generate_task(kg), .packet_task_a(pa), .rate_override_task(ro),
		.op_start, .op_decrypt, .op_rate, .op_ext_len, .op_length_bits, .op_keystream_len,
		.op_key_nonce_ptr(kp), .op_in_ptr(ip), .op_out_ptr(opp), .op_scratch_ptr(sp));

	// ****
	// checking and closing
	// ****
	task automatic check(string nm, logic [143:0] e, logic [143:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****
	// bus and task drivers
	// ****
	task automatic bus(logic [11:0] a, logic w, logic [31:0] d);
		hsel <= 1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 0;
		hsel <= 0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d, logic [31:0] e);
		bus(a, 1, d);
		m[(a - 12'h504) >> 2] = e;
	endtask

	task automatic rd(logic [11:0] a, logic [31:0] e);
		qr.push_back(e);
		bus(a, 0, $random(seed));
	endtask

	// k: 0 keystream, 1 packet_task_a, 2 rate override; held until quiet
	task automatic fire(int k);
		logic [7:0] ks;
		ks = m[0][24] ? m[5][7:0] : 8'h1b;
		if (k == 2) begin
			m[7][17:16] = m[6][1:0];
		end else begin
			m[7] = {7'h0, m[0][24], 6'h0, m[0][17:16], ks, 7'h0, m[0][0]};
			qo.push_back({m[0][0], m[0][17:16], m[0][24], m[0][24] ? 4'h8 : 4'h5, ks,
				m[1], m[2], m[3], m[4]});
		end
		kg <= k == 0;
		pa <= k == 1;
		ro <= k == 2;
		@(posedge hclk);
	endtask

	task automatic quiet();
		kg <= 0;
		pa <= 0;
		ro <= 0;
		@(posedge hclk);
	endtask

	// result watcher, oldest note first
	always @(posedge hclk) begin
		if (rd_ph) check("hrdata", {1'b1, HRESP_OKAY, qr.pop_front()}, bus_seen);
		if (op_start === 1'b1) check("op", qo.pop_front(), op_seen);
		rd_ph = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
	end

	// watchdog
	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end

	// ****
	// scenarios
	// ****
	initial begin
		logic [31:0] d;
		logic [7:0] lim[4];
		lim = '{8'h1a, 8'h1b, 8'hfb, 8'hfc};
		m = '{32'h1, 0, 0, 0, 0, 32'hfb, 0, 32'h1b01};
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		// reset values and an unmapped hole
		for (int i = 0; i < 8; i++) rd(12'h504 + 12'(i * 4), m[i]);
		rd(12'h600, 0);
		$display("test reset done");
		// every rate and length mode with a random direction, with pointers and limits
		for (int i = 0; i < 8; i++) begin
			for (int j = 1; j < 5; j++) begin
				d = $random(seed);
				wr(12'h504 + 12'(j * 4), d, d);
			end
			d = $random(seed);
			if (i < 4) d[7:0] = lim[i];
			wr(12'h518, {24'h0, d[7:0]}, {24'h0, d[7:0] < 8'h1b ? 8'h1b :
				d[7:0] > 8'hfb ? 8'hfb : d[7:0]});
			d = $random(seed);
			d[24] = i[0];
			d[17:16] = i[2:1];
			wr(12'h504, d, d & 32'h0103_0001);
			rd(12'h504, m[0]);
			fire(i % 2);
			quiet();
			rd(12'h520, m[7]);
		end
		$display("test modes done");
		// override against the configured rate, then tasks back to back
		d = $random(seed);
		d[1:0] = ~m[0][17:16];
		wr(12'h51c, d, d & 32'h3);
		rd(12'h51c, m[6]);
		fire(2);
		quiet();
		rd(12'h520, m[7]);
		rd(12'h504, m[0]);
		fire(0);
		fire(1);
		quiet();
		rd(12'h520, m[7]);
		repeat (3) @(posedge hclk);
		check("notes left", 0, qo.size() + qr.size());
		$display("test override done");
		give_verdict();
	end
endmodule // ccm_packet_packet_task_a_config_tb_top
